// ### common/aspfc_consts.vh
`ifndef ASPFC_CONSTS_VH
`define ASPFC_CONSTS_VH
// Register byte addresses
`define ASPFC_ADDR_CTRL    8'h00
`define ASPFC_ADDR_CHSEL   8'h04
`define ASPFC_ADDR_TIMING  8'h08
`define ASPFC_ADDR_STATUS  8'h0c
`define ASPFC_ADDR_RESULT  8'h10
`define ASPFC_ADDR_PINCFG  8'h14
`define ASPFC_ADDR_PORT    8'h18
// Control fields
`define ASPFC_CTRL_SAMPLE  0
`define ASPFC_CTRL_AUTO    1
`define ASPFC_CTRL_RCSEL   2
`define ASPFC_CTRL_SIDL    3
`define ASPFC_CTRL_FMT_LO  4
`define ASPFC_CTRL_ALT     6
`define ASPFC_CTRL_ON      7
`define ASPFC_CTRL_W       8
// Status fields
`define ASPFC_ST_DONE      0
`define ASPFC_ST_BUSY      1
`define ASPFC_ST_POWERED   2
`define ASPFC_ST_STABLE    3
// Output formats
`define ASPFC_FMT_INT      2'b00
`define ASPFC_FMT_SINT     2'b01
`define ASPFC_FMT_FRAC     2'b10
`define ASPFC_FMT_SFRAC    2'b11
// Reset values
`define ASPFC_CTRL_RST     8'h00
`define ASPFC_CHSEL_RST    8'h00
`define ASPFC_TAD_DIV_RST  6'h01
`define ASPFC_SAMC_RST     5'h01
`define ASPFC_PINCFG_RST   16'h0000
// Timing
`define ASPFC_CLK_MHZ      40
`define ASPFC_CONV_TAD     12
`define ASPFC_MIN_SAMPLE_CONTROL_BIT_TAD 1
`define ASPFC_T_INSTR_NS   25
`define ASPFC_T_STAB_NS    20000
`define ASPFC_RC_DIV       4
`endif

// ### logic/aspfc_ctrl.v
`timescale 1ns/1ps
`include "aspfc_consts.vh"
// Contract
// - Sampling ends either by software clearing the sample bit or automatically.
// - After a channel change a full sampling interval precedes the next conversion.
// - Module-on high powers the converter; low disables digital and analog parts.
// - In CPU sleep every converter clock source except the RC clock stops and stays low.
// - Sleep during a conversion aborts it unless the RC clock is selected; it never resumes afterwards.
// - Sleep entry and exit leave all register contents unchanged.
// - With RC clock the converter runs in sleep, delaying one instruction cycle.
// - Conversion end sets the done flag and writes the result buffer.
// - Done in sleep wakes if enabled, else converter powers off, on bit kept.
// - Stop-in-idle zero keeps running in idle; one halts during idle.
// - Reset restores registers, turns module off, aborts sampling and conversion.
// - Reset leaves the result buffer untouched; undefined after power-on.
// - Ten-bit result and buffer; two-bit format picks one of three 16-bit views, both fractional codes alike.
// - Integer right-justified, signed integer sign-extended, fractional left-justified.
// - Buffer writes are always right-justified integer data.
// - Analog pins must be inputs; an output pin converts its own digital level.
// - Sequencing ignores pin direction bits; select fields only restart sampling on a channel change.
// - Port reads return zero for every analog-configured pin.
// - A digital-input pin passes no analog level to the converter.
module aspfc_ctrl #(
  parameter NPINS    = 16,
  parameter STAB_CYC = (`ASPFC_T_STAB_NS * `ASPFC_CLK_MHZ + 999) / 1000
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire [7:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  input  wire [3:0]       avs_byteenable,
  output reg  [31:0]      avs_readdata,
  output wire             avs_waitrequest,
  input  wire             cpu_sleep,
  input  wire             cpu_idle,
  input  wire             irq_enable,
  input  wire [9:0]       ain_code,
  input  wire [NPINS-1:0] pin_direction_bits,
  input  wire [NPINS-1:0] pin_out,
  input  wire [NPINS-1:0] pin_in,
  output reg  [3:0]       ain_select,
  output reg              sample_hold,
  output reg              analog_power_on,
  output reg              adc_clk_en,
  output reg              done_pulse,
  output reg              wake_req
);
  localparam INSTR_CYC = (`ASPFC_T_INSTR_NS * `ASPFC_CLK_MHZ + 999) / 1000;
  // Manual sampling floor in conversion clocks
  localparam [4:0] MIN_SAMPLE_CONTROL_BIT = `ASPFC_MIN_SAMPLE_CONTROL_BIT_TAD;
  localparam [2:0] S_OFF = 3'd0, S_IDLE = 3'd1, S_SAMPLE_CONTROL_BIT = 3'd2, S_RCW = 3'd3, S_CONV = 3'd4;

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [15:0] fmt_view;
    input [9:0] d;
    input [1:0] f;
    begin
      case (f)
        `ASPFC_FMT_INT:  fmt_view = {6'b00_0000, d};
        `ASPFC_FMT_SINT: fmt_view = {{6{d[9]}}, d};
        default:         fmt_view = {d, 6'b00_0000};
      endcase
    end
  endfunction

  reg [`ASPFC_CTRL_W-1:0] ctrl_reg;
  reg [7:0]       chsel_reg;
  reg [5:0]       tad_div_reg;
  reg [4:0]       samc_reg;
  reg [NPINS-1:0] pincfg_reg;
  reg             done_reg;
  reg [9:0]       result_buffer;
  reg [2:0]       st_reg;
  reg [5:0]       tad_cnt_reg;
  reg [4:0]       sample_control_bit_cnt_reg;
  reg [3:0]       conv_cnt_reg;
  reg [2:0]       rcw_cnt_reg;
  reg [2:0]       rc_cnt_reg;
  reg             use_b_reg;
  reg             pwroff_reg;
  reg [15:0]      stab_cnt_reg;
  reg             ack_reg;
  reg [NPINS-1:0] pin_s1_reg;
  reg [NPINS-1:0] pin_s2_reg;

  wire sample_control_bit   = ctrl_reg[`ASPFC_CTRL_SAMPLE];
  wire auto_sample          = ctrl_reg[`ASPFC_CTRL_AUTO];
  wire rc_clock_select      = ctrl_reg[`ASPFC_CTRL_RCSEL];
  wire stop_in_idle_bit     = ctrl_reg[`ASPFC_CTRL_SIDL];
  wire [1:0] output_format_select = ctrl_reg[`ASPFC_CTRL_FMT_LO +: 2];
  wire alt_inputs           = ctrl_reg[`ASPFC_CTRL_ALT];
  wire module_on_bit        = ctrl_reg[`ASPFC_CTRL_ON];
  wire [3:0] ch0_positive_select_a = chsel_reg[3:0];
  wire [3:0] ch0_positive_select_b = chsel_reg[7:4];
  wire [NPINS-1:0] pin_analog_config = pincfg_reg;
  // Byte-lane merges, cut back to register width at the write
  wire [31:0] ctrl_merge  = be_merge({24'h00_0000, ctrl_reg}, avs_writedata, avs_byteenable);
  wire [31:0] chsel_merge = be_merge({24'h00_0000, chsel_reg}, avs_writedata, avs_byteenable);

  // Avalon: one wait state; read data is latched on the edge that raises ack, write data on the next edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  wire wr_go = avs_write & ack_reg;

  wire [3:0] chan = (alt_inputs & use_b_reg) ? ch0_positive_select_b : ch0_positive_select_a;

  // sleep stops every converter clock unless the RC source keeps running
  wire sleep_stop = cpu_sleep & ~rc_clock_select;
  // stop-in-idle freezes the sequencer during CPU idle
  wire idle_stop  = cpu_idle & stop_in_idle_bit;
  wire run        = module_on_bit & ~pwroff_reg & ~sleep_stop & ~idle_stop;

  wire rc_tick  = (rc_cnt_reg == `ASPFC_RC_DIV - 1);
  wire sys_tick = (tad_cnt_reg >= tad_div_reg);
  wire tad_tick = run & (rc_clock_select ? rc_tick : sys_tick);

  // a new channel restarts the sampling interval
  wire chan_changed = (chan != ain_select);
  wire [4:0] sample_control_bit_need = auto_sample ? ((samc_reg == 5'h00) ? 5'h01 : samc_reg)
                                     : MIN_SAMPLE_CONTROL_BIT;
  // manual sampling is stretched to the minimum if software ends it early
  wire sample_control_bit_met = (sample_control_bit_cnt_reg >= sample_control_bit_need) & ~chan_changed;
  // sampling ends on sample-bit clear or on the automatic count
  // automatic conversions start only after the programmed interval
  wire sample_control_bit_end = sample_control_bit_met & (auto_sample | ~sample_control_bit);
  wire conv_fin = (st_reg == S_CONV) & tad_tick & (conv_cnt_reg == `ASPFC_CONV_TAD - 1);

  // an output pin converts its own driven level
  // a digital-configured pin yields no analog code
  wire [9:0] conv_val = pin_analog_config[chan] ? 10'h000 :
                        (~pin_direction_bits[chan] ? {10{pin_out[chan]}} : ain_code);

  reg [2:0] st_next;
  always @* begin
    st_next = st_reg;
    case (st_reg)
      S_OFF:  if (module_on_bit & ~pwroff_reg) st_next = S_IDLE;
      S_IDLE: if (run & (sample_control_bit | auto_sample)) st_next = S_SAMPLE_CONTROL_BIT;
      S_SAMPLE_CONTROL_BIT: if (tad_tick & sample_control_bit_end) st_next = rc_clock_select ? S_RCW : S_CONV;
      S_RCW:  if (run & (rcw_cnt_reg == INSTR_CYC - 1)) st_next = S_CONV;
      S_CONV: if (conv_fin) st_next = S_IDLE;
      default: st_next = S_OFF;
    endcase
    // sleep mid-conversion drops it for good
    if (sleep_stop & ((st_reg == S_CONV) | (st_reg == S_RCW)))
      st_next = S_IDLE;
    if (~module_on_bit | pwroff_reg)
      st_next = S_OFF;
  end

  // RC mode waits one instruction cycle before converting
  always @(posedge clk) begin
    if (!rstn)
      rcw_cnt_reg <= 3'd0;
    else if (st_reg != S_RCW)
      rcw_cnt_reg <= 3'd0;
    else if (run)
      rcw_cnt_reg <= rcw_cnt_reg + 3'd1;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      tad_cnt_reg <= 6'h00;
      rc_cnt_reg  <= 3'd0;
    end else begin
      if (!run || sys_tick)
        tad_cnt_reg <= 6'h00;
      else
        tad_cnt_reg <= tad_cnt_reg + 6'h01;
      if (!run || rc_tick)
        rc_cnt_reg <= 3'd0;
      else
        rc_cnt_reg <= rc_cnt_reg + 3'd1;
    end
  end

  // reset turns the module off and aborts any sequence
  // sequencing reads no direction bits; select fields only restart sampling on a channel change
  always @(posedge clk) begin
    if (!rstn) begin
      st_reg       <= S_OFF;
      sample_control_bit_cnt_reg <= 5'h00;
      conv_cnt_reg <= 4'h0;
      use_b_reg    <= 1'b0;
      ain_select   <= 4'h0;
    end else begin
      st_reg     <= st_next;
      ain_select <= chan;
      if (st_reg != S_SAMPLE_CONTROL_BIT || chan_changed)
        sample_control_bit_cnt_reg <= 5'h00;
      else if (tad_tick && sample_control_bit_cnt_reg != 5'h1f)
        sample_control_bit_cnt_reg <= sample_control_bit_cnt_reg + 5'h01;
      if (st_reg != S_CONV)
        conv_cnt_reg <= 4'h0;
      else if (tad_tick)
        conv_cnt_reg <= conv_cnt_reg + 4'h1;
      if (conv_fin)
        // Alternate inputs swap channel after each result
        use_b_reg <= alt_inputs & ~use_b_reg;
    end
  end

  // buffer has no reset so a device reset keeps its contents
  always @(posedge clk) begin
    if (conv_fin)
      result_buffer <= conv_val;
    // bus writes land right-justified regardless of format
    else if (wr_go && avs_address == `ASPFC_ADDR_RESULT && avs_byteenable[1:0] == 2'b11)
      result_buffer <= avs_writedata[9:0];
  end

  // stable flag lets software see the power-up settling time
  always @(posedge clk) begin
    if (!rstn)
      stab_cnt_reg <= 16'h0000;
    else if (!analog_power_on)
      stab_cnt_reg <= 16'h0000;
    else if (stab_cnt_reg < STAB_CYC)
      stab_cnt_reg <= stab_cnt_reg + 16'h0001;
  end

  // sleep touches no register; only hardware events below change them
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg    <= `ASPFC_CTRL_RST;
      chsel_reg   <= `ASPFC_CHSEL_RST;
      tad_div_reg <= `ASPFC_TAD_DIV_RST;
      samc_reg    <= `ASPFC_SAMC_RST;
      pincfg_reg  <= `ASPFC_PINCFG_RST;
      done_reg    <= 1'b0;
      pwroff_reg  <= 1'b0;
    end else begin
      if (wr_go) begin
        case (avs_address)
          `ASPFC_ADDR_CTRL:   ctrl_reg <= ctrl_merge[`ASPFC_CTRL_W-1:0];
          `ASPFC_ADDR_CHSEL:  chsel_reg <= chsel_merge[7:0];
          `ASPFC_ADDR_TIMING: begin
            if (avs_byteenable[0])
              tad_div_reg <= avs_writedata[5:0];
            if (avs_byteenable[1])
              samc_reg <= avs_writedata[12:8];
          end
          `ASPFC_ADDR_PINCFG: begin
            if (avs_byteenable[0])
              pincfg_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              pincfg_reg[NPINS-1:8] <= avs_writedata[NPINS-1:8];
          end
          `ASPFC_ADDR_STATUS:
            if (avs_byteenable[0] && avs_writedata[`ASPFC_ST_DONE])
              done_reg <= 1'b0;
          default: ;
        endcase
      end
      // Hardware updates after software so a same-cycle event wins
      if (st_reg == S_SAMPLE_CONTROL_BIT && tad_tick && sample_control_bit_end && auto_sample)
        ctrl_reg[`ASPFC_CTRL_SAMPLE] <= 1'b0;
      if (conv_fin) begin
        done_reg <= 1'b1;
        if (auto_sample)
          ctrl_reg[`ASPFC_CTRL_SAMPLE] <= 1'b1;
        // done in sleep without wake powers the converter down
        if (cpu_sleep && !irq_enable)
          pwroff_reg <= 1'b1;
      end
      // Writing the on bit low or a reset are the only exits from self power-off
      if (!module_on_bit)
        pwroff_reg <= 1'b0;
    end
  end

  // analog-configured pins read back as zero
  wire [NPINS-1:0] port_view = pin_s2_reg & pin_analog_config;

  // formatted 16-bit view of the ten-bit buffer
  // format field picks integer, signed or fractional layout
  wire [15:0] res_view = fmt_view(result_buffer, output_format_select);

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `ASPFC_ADDR_CTRL:   rd_mux = {24'h00_0000, ctrl_reg};
      `ASPFC_ADDR_CHSEL:  rd_mux = {24'h00_0000, chsel_reg};
      `ASPFC_ADDR_TIMING: rd_mux = {19'h0_0000, samc_reg, 2'b00, tad_div_reg};
      `ASPFC_ADDR_STATUS: rd_mux = {28'h000_0000, stab_cnt_reg >= STAB_CYC,
                                    analog_power_on, st_reg == S_CONV, done_reg};
      `ASPFC_ADDR_RESULT: rd_mux = {16'h0000, res_view};
      `ASPFC_ADDR_PINCFG: rd_mux = {{(32-NPINS){1'b0}}, pincfg_reg};
      `ASPFC_ADDR_PORT:   rd_mux = {{(32-NPINS){1'b0}}, port_view};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      pin_s1_reg   <= {NPINS{1'b0}};
      pin_s2_reg   <= {NPINS{1'b0}};
    end else begin
      ack_reg    <= (avs_read | avs_write) & ~ack_reg;
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      if (avs_read && !ack_reg)
        avs_readdata <= rd_mux;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      sample_hold     <= 1'b0;
      analog_power_on <= 1'b0;
      adc_clk_en      <= 1'b0;
      done_pulse      <= 1'b0;
      wake_req        <= 1'b0;
    end else begin
      sample_hold     <= (st_next == S_SAMPLE_CONTROL_BIT);
      analog_power_on <= module_on_bit & ~pwroff_reg;
      // clock enable held low whenever clocks must stop
      adc_clk_en      <= tad_tick;
      done_pulse      <= conv_fin;
      // enabled interrupt wakes the CPU from sleep
      wake_req        <= conv_fin & cpu_sleep & irq_enable;
    end
  end

endmodule // aspfc_ctrl

// ### sim/aspfc_ctrl_sva.sv
`timescale 1ns/1ps
`include "aspfc_consts.vh"
module aspfc_ctrl_sva (
  input logic        clk,
  input logic        rstn,
  input logic [7:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        cpu_sleep,
  input logic        cpu_idle,
  input logic        irq_enable,
  input logic        sample_hold,
  input logic        analog_power_on,
  input logic        adc_clk_en,
  input logic        done_pulse,
  input logic        wake_req
);
  // Shadows track only completed writes, so they flip on the same edge as the registers
  logic [7:0]  ctrl_reg;
  logic [15:0] pcfg_reg;
  wire         wr_ok  = avs_write && !avs_waitrequest;
  wire         rd_ok  = avs_read && !avs_waitrequest;
  wire         rc_b   = ctrl_reg[2];
  wire         sidl_b = ctrl_reg[3];
  wire         on_b   = ctrl_reg[7];
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= 8'h00;
      pcfg_reg <= 16'h0000;
    end else if (wr_ok) begin
      if (avs_address == `ASPFC_ADDR_CTRL && avs_byteenable[0]) ctrl_reg <= avs_writedata[7:0];
      if (avs_address == `ASPFC_ADDR_PINCFG && avs_byteenable[0]) pcfg_reg[7:0] <= avs_writedata[7:0];
      if (avs_address == `ASPFC_ADDR_PINCFG && avs_byteenable[1]) pcfg_reg[15:8] <= avs_writedata[15:8];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Three cycles of sleep leave slack for the registered abort path
  sequence slept_s;
    cpu_sleep [*3];
  endsequence
  sequence res_rd_s;
    rd_ok && avs_address == `ASPFC_ADDR_RESULT;
  endsequence
  reset_off_a: assert property (disable iff (1'b0)
    !rstn |=> !analog_power_on && !sample_hold) else $error("converter active after reset");
  power_off_a: assert property (!on_b && !$past(on_b) |-> !analog_power_on && !adc_clk_en)
    else $error("converter powered while switched off");
  sleep_clk_a: assert property (cpu_sleep && $past(cpu_sleep) && !rc_b && !$past(rc_b)
    |-> !adc_clk_en) else $error("conversion clock runs in sleep");
  sleep_abort_a: assert property (slept_s ##0 !rc_b && !$past(rc_b) |-> !done_pulse)
    else $error("conversion finished during sleep");
  idle_stop_a: assert property (cpu_idle && $past(cpu_idle) && sidl_b && $past(sidl_b)
    |-> !adc_clk_en) else $error("conversion clock runs in stopped idle");
  done_once_a: assert property (done_pulse |=> !done_pulse)
    else $error("done pulse longer than one cycle");
  wake_cause_a: assert property (wake_req |-> $past(cpu_sleep) && $past(irq_enable))
    else $error("wake request without sleep and enabled interrupt");
  port_mask_a: assert property (rd_ok && avs_address == `ASPFC_ADDR_PORT
    |-> (avs_readdata[15:0] & ~pcfg_reg) == 16'h0000) else $error("analog pin reads as set");
  fmt_int_a: assert property (res_rd_s ##0 ctrl_reg[5:4] == `ASPFC_FMT_INT
    |-> avs_readdata[15:10] == 6'h00) else $error("integer read has upper bits set");
  fmt_sint_a: assert property (res_rd_s ##0 ctrl_reg[5:4] == `ASPFC_FMT_SINT
    |-> avs_readdata[15:10] == {6{avs_readdata[9]}}) else $error("signed read not extended");
  fmt_frac_a: assert property (res_rd_s ##0 ctrl_reg[5] |-> avs_readdata[5:0] == 6'h00)
    else $error("fractional read has low bits set");
endmodule // aspfc_ctrl_sva
bind aspfc_ctrl aspfc_ctrl_sva u_sva (.clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_sleep, .cpu_idle,
  .irq_enable, .sample_hold, .analog_power_on, .adc_clk_en, .done_pulse, .wake_req);

// ### sim/testbench.sv
`timescale 1ns/1ps
`include "aspfc_consts.vh"
module testbench;
  localparam logic [7:0] a_ct = `ASPFC_ADDR_CTRL;
  localparam logic [7:0] a_st = `ASPFC_ADDR_STATUS;
  localparam logic [7:0] a_rs = `ASPFC_ADDR_RESULT;
  localparam logic [7:0] a_pc = `ASPFC_ADDR_PINCFG;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        cpu_sleep = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        irq_enable = 1'b0;
  logic [9:0]  ain_code = 10'h155;
  logic [15:0] pin_direction_bits = 16'hffff;
  logic [15:0] pin_out = 16'h0000;
  logic [15:0] pin_in = 16'h0000;
  logic [31:0] q;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, sample_hold, analog_power_on, adc_clk_en, done_pulse, wake_req;
  wire  [3:0]  ain_select;
  int          miscompares = 0;
  int          n_checks = 0;
  int          n_tick = 0;
  int          n_wake = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (adc_clk_en) n_tick <= n_tick + 1;
    if (wake_req) n_wake <= n_wake + 1;
  end
  aspfc_ctrl #(.NPINS(16), .STAB_CYC(8)) DUT (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_sleep, .cpu_idle,
    .irq_enable, .ain_code, .pin_direction_bits, .pin_out, .pin_in, .ain_select,
    .sample_hold, .analog_power_on, .adc_clk_en, .done_pulse, .wake_req);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge; read data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) chk(n, 0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done_pulse !== 1'b1 && k < lim);
  endtask
  task automatic conv(input logic [7:0] c, input logic [31:0] e);
    bus(1'b1, a_ct, {24'h00_0000, c | 8'h01});
    bus(1'b1, a_ct, {24'h00_0000, c});
    wait_done(300);
    chk(done_pulse, 1'b1);
    rdc(a_rs, e);
  endtask
  task automatic t_reset;
    rdc(a_ct, 32'h0000_0000);
    rdc(`ASPFC_ADDR_CHSEL, 32'h0000_0000);
    rdc(`ASPFC_ADDR_TIMING, 32'h0000_0101);
    rdc(a_pc, 32'h0000_0000);
    bus(1'b1, 8'h1c, 32'hffff_ffff);
    rdc(8'h1c, 32'h0000_0000);
    $display("test reset values done");
  endtask
  task automatic t_format;
    logic [31:0] fx [4];
    fx = '{32'h0000_02a5, 32'h0000_fea5, 32'h0000_a940, 32'h0000_a940};
    bus(1'b1, a_rs, 32'h0000_fea5);
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, a_ct, 32'(f) << 4);
      rdc(a_rs, fx[f]);
    end
    $display("test formats done");
  endtask
  task automatic t_pins;
    bus(1'b1, a_ct, 32'h0000_0080);
    repeat (12) @(posedge clk);
    bus(1'b1, `ASPFC_ADDR_CHSEL, 32'h0000_0050);
    conv(8'h80, 32'h0000_0155);
    rdc(a_st, 32'h0000_000d);
    bus(1'b1, a_st, 32'h0000_0001);
    pin_direction_bits <= 16'hfffe;
    pin_out <= 16'h0001;
    conv(8'h80, 32'h0000_03ff);
    pin_direction_bits <= 16'hffff;
    bus(1'b1, a_pc, 32'h0000_0001);
    conv(8'h80, 32'h0000_0000);
    bus(1'b1, a_pc, 32'h0000_0000);
    ain_code <= 10'h0aa;
    conv(8'h82, 32'h0000_00aa);
    bus(1'b1, a_ct, 32'h0000_0080);
    wait_done(100);
    @(posedge clk);
    pin_direction_bits <= 16'hffdf;
    pin_out <= 16'h0020;
    conv(8'hc0, 32'h0000_00aa);
    chk(ain_select, 32'h0000_0005);
    conv(8'hc0, 32'h0000_03ff);
    chk(ain_select, 32'h0000_0000);
    pin_direction_bits <= 16'hffff;
    $display("test conversions done");
  endtask
  task automatic t_port;
    @(posedge clk);
    pin_in <= 16'ha5a5;
    bus(1'b1, a_pc, 32'h0000_00ff);
    repeat (4) @(posedge clk);
    rdc(`ASPFC_ADDR_PORT, 32'h0000_00a5);
    bus(1'b1, a_pc, 32'h0000_0000);
    rdc(`ASPFC_ADDR_PORT, 32'h0000_0000);
    $display("test port reads done");
  endtask
  task automatic t_sleep;
    int t0;
    bus(1'b1, a_ct, 32'h0000_0081);
    bus(1'b1, a_ct, 32'h0000_0080);
    t0 = 0;
    do begin
      bus(1'b0, a_st, 32'h0000_0000);
      t0++;
    end while (q[1] !== 1'b1 && t0 < 20);
    chk(q[1], 1'b1);
    cpu_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    t0 = n_tick;
    repeat (40) @(posedge clk);
    chk(n_tick - t0, 0);
    cpu_sleep <= 1'b0;
    wait_done(150);
    chk(done_pulse, 1'b0);
    rdc(a_ct, 32'h0000_0080);
    $display("test sleep abort done");
  endtask
  task automatic t_rc;
    int w0;
    for (int i = 0; i < 2; i++) begin
      irq_enable <= (i == 0);
      w0 = n_wake;
      bus(1'b1, a_ct, 32'h0000_0085);
      cpu_sleep <= 1'b1;
      bus(1'b1, a_ct, 32'h0000_0084);
      wait_done(400);
      chk(done_pulse, 1'b1);
      repeat (3) @(negedge clk);
      chk(n_wake - w0, (i == 0));
      chk(analog_power_on, (i == 0));
      @(posedge clk);
      cpu_sleep <= 1'b0;
      rdc(a_ct, 32'h0000_0084);
    end
    bus(1'b1, a_ct, 32'h0000_0000);
    $display("test rc sleep done");
  endtask
  task automatic t_idle;
    int t0;
    bus(1'b1, a_ct, 32'h0000_0089);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clk);
    t0 = n_tick;
    repeat (20) @(posedge clk);
    chk(n_tick - t0, 0);
    bus(1'b1, a_ct, 32'h0000_0081);
    repeat (20) @(posedge clk);
    chk(n_tick != t0, 1'b1);
    cpu_idle <= 1'b0;
    bus(1'b1, a_ct, 32'h0000_0080);
    wait_done(200);
    chk(done_pulse, 1'b1);
    $display("test idle done");
  endtask
  task automatic t_rerun;
    bus(1'b1, a_rs, 32'h0000_0123);
    bus(1'b1, a_ct, 32'h0000_0081);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(analog_power_on, 1'b0);
    chk(sample_hold, 1'b0);
    rdc(a_ct, 32'h0000_0000);
    rdc(a_rs, 32'h0000_0123);
    $display("test second reset done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_format();
    t_pins();
    t_port();
    t_sleep();
    t_rc();
    t_idle();
    t_rerun();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule // testbench
